//--- design/rtcrc_pkg.sv
// package: constants and state type for the rtc reset, interrupt and square-wave control block
package rtcrc_pkg;

  // ****************************************************************
  // register offsets on the byte bus
  // ****************************************************************
  localparam logic [6:0] ADDR_RATE_CTRL = 7'h0A;
  localparam logic [6:0] ADDR_MODE_CTRL = 7'h0B;
  localparam logic [6:0] ADDR_INT_STATUS = 7'h0C;
  localparam logic [6:0] ADDR_RAM_FIRST = 7'h0E;
  localparam logic [6:0] ADDR_RAM_LAST = 7'h7F;

  // ****************************************************************
  // memory geometry
  // ****************************************************************
  localparam int RAM_BYTES = 114;
  localparam logic [7:0] RAM_CLEAR_VALUE = 8'hFF;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int MODE_PERIODIC_EN_BIT = 6;
  localparam int MODE_ALARM_EN_BIT = 5;
  localparam int MODE_UPDATE_EN_BIT = 4;
  localparam int MODE_WAVE_EN_BIT = 3;
  localparam int STAT_SUMMARY_BIT = 7;
  localparam int STAT_PERIODIC_BIT = 6;
  localparam int STAT_ALARM_BIT = 5;
  localparam int STAT_UPDATE_BIT = 4;
  localparam int RATE_SEL_WIDTH = 4;

  // ****************************************************************
  // divider chain and rate-select taps
  // ****************************************************************
  localparam int DIV_STAGES = 15;
  localparam logic [3:0] RATE_OFF = 4'h0;
  localparam logic [3:0] RATE_256HZ = 4'h1;
  localparam logic [3:0] RATE_128HZ = 4'h2;
  localparam logic [3:0] RATE_TAP_OFFSET = 4'h2;
  localparam logic [3:0] TAP_256HZ = 4'h6;
  localparam logic [3:0] TAP_128HZ = 4'h7;

  // ****************************************************************
  // reset values and synchroniser
  // ****************************************************************
  localparam logic [7:0] MODE_CTRL_RESET = 8'h00;
  localparam logic [3:0] RATE_CTRL_RESET = 4'h0;
  localparam logic [7:0] READ_IDLE_VALUE = 8'h00;
  localparam int SYNC_LEVELS = 2;
  localparam logic [1:0] SYNC_RESET = 2'h1;

  // ****************************************************************
  // state of the control block
  // ****************************************************************
  typedef struct packed {
    logic [3:0] rateSelect;
    logic [7:0] modeCtrl;
    logic listedAlarmFlag;
    logic alarmFlag;
    logic updateDoneFlag;
    logic anyInterruptFlag;
    logic [DIV_STAGES-1:0] divChain;
    logic tapPrev;
    logic squareWaveOut;
    logic irqDriveN;
    logic [7:0] busRdata;
    logic busRvalid;
    logic busRefused;
    logic hostAccessOk;
  } rtcrc_state_type;

endpackage

//--- design/rtcrc_sync_if.sv
// interface: raw and synchronised supervision levels between the control block and its synchroniser
`timescale 1ns/10ps
interface rtcrc_sync_if;
  logic [rtcrc_pkg::SYNC_LEVELS-1:0] rawLevel;
  logic [rtcrc_pkg::SYNC_LEVELS-1:0] syncLevel;

  modport owner (output rawLevel, input syncLevel);
  modport syncer (input rawLevel, output syncLevel);
endinterface

//--- design/rtcrc_level_sync.sv
// module: two-flop synchroniser for the supervision levels
`timescale 1ns/10ps
module rtcrc_level_sync (
  input wire logic clk_sys,
  input wire logic srst,
  rtcrc_sync_if.syncer levels
);

  typedef struct packed {
    logic [rtcrc_pkg::SYNC_LEVELS-1:0] stage1;
    logic [rtcrc_pkg::SYNC_LEVELS-1:0] stage2;
  } rtcrc_sync_state_type;

  rtcrc_sync_state_type state_reg;
  rtcrc_sync_state_type state_next;

  // the first stage feeds only the second, never the logic behind it
  always_comb begin
    state_next.stage1 = levels.rawLevel;
    state_next.stage2 = state_reg.stage1;
  end

  // reset value keeps the pin released and supply good
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_reg <= {rtcrc_pkg::SYNC_RESET, rtcrc_pkg::SYNC_RESET};
    end else begin
      state_reg <= state_next;
    end
  end

  assign levels.syncLevel = state_reg.stage2;

endmodule // rtcrc_level_sync

//--- design/rtcrc_control.sv
// module: reset, interrupt, square-wave, ram-clear and power-fail access control of the clock unit
//
// Behaviour
// - external reset clears the three interrupt enables
// - external reset clears periodic, update and summary flags
// - external reset releases the interrupt pin
// - no bus access while reset pin low
// - external reset clears square-wave enable
// - reset leaves time, calendar and memory alone
// - interrupt pin low while enabled flag set
// - reading status clears flags, releases pin
// - interrupt pin is open drain, low only
// - ram clear sets all 114 bytes high
// - ram clear only on backup supply
// - square wave from 13 divider taps
// - square-wave enable gates the output
// - no square wave below power-fail trip
// - all accesses blocked below power-fail trip
// - chip select ignored below power-fail trip
`timescale 1ns/10ps
module rtcrc_control (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic resetPinN,
  input wire logic power_fail_threshold,
  input wire logic ram_clear_n,
  input wire logic oscTick,
  input wire logic alarmEvent,
  input wire logic updateDoneEvent,
  input wire logic busCsN,
  input wire logic busRead,
  input wire logic busWrite,
  input wire logic [6:0] busAddr,
  input wire logic [7:0] busWdata,
  output logic [7:0] busRdata,
  output logic busRvalid,
  output logic busRefused,
  output logic hostAccessOk,
  input wire logic irqPinIn,
  output logic irqPinOut,
  output logic irqPinOeN,
  output logic square_wave_out,
  output logic periodic_int_enable,
  output logic alarm_int_enable,
  output logic update_done_int_enable,
  output logic square_wave_enable,
  output logic listed_alarm_flag,
  output logic update_done_flag,
  output logic any_interrupt_flag,
  output logic [3:0] rateSelect
);

  // ****************************************************************
  // synchronised supervision levels
  // ****************************************************************
  rtcrc_sync_if levelBus ();

  // bit 0: reset pin, bit 1: supply below trip point
  assign levelBus.rawLevel = {power_fail_threshold, resetPinN};

  // both levels pass the same two stages, so a pin change acts three edges later
  rtcrc_level_sync levelSync (
    .clk_sys(clk_sys),
    .srst(srst),
    .levels(levelBus)
  );

  // supervision levels as this clock domain sees them
  logic resetSyncN;
  logic powerFailSync;
  logic extResetActive;
  logic accessAllowed;

  assign resetSyncN = levelBus.syncLevel[0];
  assign powerFailSync = levelBus.syncLevel[1];
  // the pin only acts while supply is good; below the trip point the bus and the square wave are blocked anyway
  assign extResetActive = !resetSyncN && !powerFailSync;
  // chip select is masked inside below the trip point and while the reset pin is low
  assign accessAllowed = resetSyncN && !powerFailSync;

  // ****************************************************************
  // state registers
  // ****************************************************************
  // every register of the block except the memory and the synchroniser flops sits in this struct
  rtcrc_pkg::rtcrc_state_type state_reg;
  rtcrc_pkg::rtcrc_state_type state_next;

  // backed-up bytes, changed only by a host write or a backup-supply clear
  logic [7:0] ramArray [0:rtcrc_pkg::RAM_BYTES-1];

  // ****************************************************************
  // bus decode
  // ****************************************************************
  logic busSelected;
  logic readStrobe;
  logic writeStrobe;
  logic ramHit;
  logic [6:0] ramIndex;
  logic statusRead;

  // a read wins when both strobes are high, so a write needs read low
  assign busSelected = !busCsN && (busRead || busWrite);
  assign readStrobe = !busCsN && busRead && accessAllowed;
  assign writeStrobe = !busCsN && busWrite && !busRead && accessAllowed;

  // memory runs from its first byte to the top of the map; the index is used only on a hit
  assign ramHit = (busAddr >= rtcrc_pkg::ADDR_RAM_FIRST);
  assign ramIndex = busAddr - rtcrc_pkg::ADDR_RAM_FIRST;

  // of all bus accesses, only an accepted read of the status byte clears the flags
  assign statusRead = readStrobe && (busAddr == rtcrc_pkg::ADDR_INT_STATUS);

  // ****************************************************************
  // divider tap selection
  // ****************************************************************
  logic [3:0] tapIndex;
  logic tapValue;
  logic periodicEdge;

  // rate 1 and 2 repeat two low taps; 3 to 15 walk down the chain, 13 taps in all
  always_comb begin
    tapIndex = 4'h0;
    case (state_reg.rateSelect)
      rtcrc_pkg::RATE_OFF: tapIndex = 4'h0;
      rtcrc_pkg::RATE_256HZ: tapIndex = rtcrc_pkg::TAP_256HZ;
      rtcrc_pkg::RATE_128HZ: tapIndex = rtcrc_pkg::TAP_128HZ;
      default: tapIndex = state_reg.rateSelect - rtcrc_pkg::RATE_TAP_OFFSET;
    endcase
  end

  // rate zero stops the tap, the periodic flag and the square wave together
  assign tapValue = (state_reg.rateSelect != rtcrc_pkg::RATE_OFF) && state_reg.divChain[tapIndex];
  // rising edge of the tap, seen in the same cycle as the divider bit rises
  assign periodicEdge = tapValue && !state_reg.tapPrev;

  // ****************************************************************
  // read data mux
  // ****************************************************************
  logic [7:0] readData;
  logic [7:0] statusByte;

  // status byte as the host reads it; the low nibble reads zero
  always_comb begin
    statusByte = 8'h00;
    statusByte[rtcrc_pkg::STAT_SUMMARY_BIT] = state_reg.anyInterruptFlag;
    statusByte[rtcrc_pkg::STAT_PERIODIC_BIT] = state_reg.listedAlarmFlag;
    statusByte[rtcrc_pkg::STAT_ALARM_BIT] = state_reg.alarmFlag;
    statusByte[rtcrc_pkg::STAT_UPDATE_BIT] = state_reg.updateDoneFlag;
  end

  // clock and calendar bytes belong to the counters and read as idle here
  always_comb begin
    readData = rtcrc_pkg::READ_IDLE_VALUE;
    if (ramHit) begin
      readData = ramArray[ramIndex];
    end else begin
      case (busAddr)
        rtcrc_pkg::ADDR_RATE_CTRL: readData = {4'h0, state_reg.rateSelect};
        rtcrc_pkg::ADDR_MODE_CTRL: readData = state_reg.modeCtrl;
        rtcrc_pkg::ADDR_INT_STATUS: readData = statusByte;
        default: readData = rtcrc_pkg::READ_IDLE_VALUE;
      endcase
    end
  end

  // ****************************************************************
  // next-state logic
  // ****************************************************************
  // enables as they will stand after this edge, feeding the summary flag
  logic periodicEnNext;
  logic alarmEnNext;
  logic updateEnNext;
  logic irqPending;

  always_comb begin
    state_next = state_reg;
    periodicEnNext = 1'b0;
    alarmEnNext = 1'b0;
    updateEnNext = 1'b0;
    irqPending = 1'b0;

    // divider keeps counting through the reset pin and outages, but srst clears it
    if (oscTick) begin
      state_next.divChain = state_reg.divChain + 15'h0001;
    end
    // remembered tap finds the rising edge for the periodic flag
    state_next.tapPrev = tapValue;

    // control register writes
    if (writeStrobe && !ramHit) begin
      case (busAddr)
        rtcrc_pkg::ADDR_RATE_CTRL: state_next.rateSelect = busWdata[3:0];
        rtcrc_pkg::ADDR_MODE_CTRL: state_next.modeCtrl = busWdata;
        default: state_next.modeCtrl = state_reg.modeCtrl;
      endcase
    end

    // reading status clears the flags first; a new event in the same cycle still sets
    if (statusRead) begin
      state_next.listedAlarmFlag = 1'b0;
      state_next.alarmFlag = 1'b0;
      state_next.updateDoneFlag = 1'b0;
    end
    if (periodicEdge) begin
      state_next.listedAlarmFlag = 1'b1;
    end
    if (alarmEvent) begin
      state_next.alarmFlag = 1'b1;
    end
    if (updateDoneEvent) begin
      state_next.updateDoneFlag = 1'b1;
    end

    // the reset pin clears enables and flags but never the alarm flag, time or memory
    if (extResetActive) begin
      state_next.modeCtrl[rtcrc_pkg::MODE_PERIODIC_EN_BIT] = 1'b0;
      state_next.modeCtrl[rtcrc_pkg::MODE_ALARM_EN_BIT] = 1'b0;
      state_next.modeCtrl[rtcrc_pkg::MODE_UPDATE_EN_BIT] = 1'b0;
      state_next.modeCtrl[rtcrc_pkg::MODE_WAVE_EN_BIT] = 1'b0;
      state_next.listedAlarmFlag = 1'b0;
      state_next.updateDoneFlag = 1'b0;
    end

    // summary flag follows the flags and enables that will stand next cycle
    periodicEnNext = state_next.modeCtrl[rtcrc_pkg::MODE_PERIODIC_EN_BIT];
    alarmEnNext = state_next.modeCtrl[rtcrc_pkg::MODE_ALARM_EN_BIT];
    updateEnNext = state_next.modeCtrl[rtcrc_pkg::MODE_UPDATE_EN_BIT];
    irqPending = (state_next.listedAlarmFlag && periodicEnNext) || (state_next.alarmFlag && alarmEnNext)
      || (state_next.updateDoneFlag && updateEnNext);
    state_next.anyInterruptFlag = irqPending && !extResetActive;
    // open drain: enable low pulls the line, otherwise released
    state_next.irqDriveN = !(irqPending && !extResetActive);

    // square wave needs the enable and good supply
    state_next.squareWaveOut = tapValue && state_next.modeCtrl[rtcrc_pkg::MODE_WAVE_EN_BIT]
      && !powerFailSync;

    // bus answer
    state_next.busRvalid = readStrobe;
    state_next.busRefused = busSelected && !accessAllowed;
    state_next.hostAccessOk = accessAllowed;
    if (readStrobe) begin
      state_next.busRdata = readData;
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_reg <= '0;
      state_reg.rateSelect <= rtcrc_pkg::RATE_CTRL_RESET;
      state_reg.modeCtrl <= rtcrc_pkg::MODE_CTRL_RESET;
      state_reg.irqDriveN <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // general-purpose memory
  // ****************************************************************
  // kept apart from the state struct and outside srst so nothing but a host write or
  // a backup-supply clear changes it
  always_ff @(posedge clk_sys) begin
    if (!ram_clear_n && powerFailSync) begin
      for (int i = 0; i < rtcrc_pkg::RAM_BYTES; i++) begin
        ramArray[i] <= rtcrc_pkg::RAM_CLEAR_VALUE;
      end
    end else if (writeStrobe && ramHit) begin
      ramArray[ramIndex] <= busWdata;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // bus answer, one cycle after the strobe
  assign busRdata = state_reg.busRdata;
  assign busRvalid = state_reg.busRvalid;
  assign busRefused = state_reg.busRefused;
  assign hostAccessOk = state_reg.hostAccessOk;

  // open-drain pin: the level is always low, only the enable moves, so it can share a line
  assign irqPinOut = 1'b0;
  assign irqPinOeN = state_reg.irqDriveN;

  // square wave is already gated by enable and supply in the struct
  assign square_wave_out = state_reg.squareWaveOut;

  // control bits and flags as the host would read them
  assign periodic_int_enable = state_reg.modeCtrl[rtcrc_pkg::MODE_PERIODIC_EN_BIT];
  assign alarm_int_enable = state_reg.modeCtrl[rtcrc_pkg::MODE_ALARM_EN_BIT];
  assign update_done_int_enable = state_reg.modeCtrl[rtcrc_pkg::MODE_UPDATE_EN_BIT];
  assign square_wave_enable = state_reg.modeCtrl[rtcrc_pkg::MODE_WAVE_EN_BIT];
  assign listed_alarm_flag = state_reg.listedAlarmFlag;
  assign update_done_flag = state_reg.updateDoneFlag;
  assign any_interrupt_flag = state_reg.anyInterruptFlag;
  assign rateSelect = state_reg.rateSelect;

endmodule // rtcrc_control

//--- test/rtcrc_host_model.sv
// host processor model: byte bus cycles and the pulled-up interrupt line
`timescale 1ns/10ps
module rtcrc_host_model (
  input wire logic clk_sys,
  output logic busCsN,
  output logic busRead,
  output logic busWrite,
  output logic [6:0] busAddr,
  output logic [7:0] busWdata,
  input wire logic [7:0] busRdata,
  input wire logic busRefused,
  input wire logic irqPinOut,
  input wire logic irqPinOeN,
  output logic irqLine
);
  // shared line with a pull-up: released means high, never the last driven value
  assign irqLine = irqPinOeN ? 1'b1 : irqPinOut;
  initial begin
    busCsN = 1'b1;
    busRead = 1'b0;
    busWrite = 1'b0;
    busAddr = 7'h00;
    busWdata = 8'h00;
  end
  // one strobe cycle; released lines are inverted so stale values never look valid
  task automatic cycle(input logic wr, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q,
                       output logic ok);
    @(posedge clk_sys);
    busCsN <= 1'b0;
    busRead <= !wr;
    busWrite <= wr;
    busAddr <= a;
    busWdata <= d;
    @(posedge clk_sys);
    busCsN <= 1'b1;
    busRead <= 1'b0;
    busWrite <= 1'b0;
    busAddr <= ~a;
    busWdata <= ~d;
    #1;
    q = busRdata;
    ok = !busRefused;
  endtask
endmodule // rtcrc_host_model

//--- test/rtcrc_control_chk.sv
// checker: port-level relations of the reset, interrupt and square-wave control block
`timescale 1ns/10ps
module rtcrc_control_chk (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic resetPinN,
  input wire logic power_fail_threshold,
  input wire logic busCsN,
  input wire logic busRead,
  input wire logic busWrite,
  input wire logic busRvalid,
  input wire logic busRefused,
  input wire logic irqPinOut,
  input wire logic irqPinOeN,
  input wire logic square_wave_out,
  input wire logic periodic_int_enable,
  input wire logic alarm_int_enable,
  input wire logic update_done_int_enable,
  input wire logic square_wave_enable,
  input wire logic listed_alarm_flag,
  input wire logic update_done_flag,
  input wire logic any_interrupt_flag
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  wire logic strobe = !busCsN && (busRead || busWrite);
  // three edges: two synchroniser flops plus the state register
  sequence s_pinLow; (!resetPinN && !power_fail_threshold)[*3]; endsequence
  sequence s_outage; power_fail_threshold[*3]; endsequence
  a_reset_enables_off: assert property (s_pinLow |=> !periodic_int_enable && !alarm_int_enable && !update_done_int_enable)
    else $error("enables kept under reset pin");
  a_reset_flags_off: assert property (s_pinLow |=> !listed_alarm_flag && !update_done_flag && !any_interrupt_flag)
    else $error("flags kept under reset pin");
  a_reset_irq_float: assert property (s_pinLow |=> irqPinOeN)
    else $error("interrupt driven under reset pin");
  a_reset_square_wave_enable_off: assert property (s_pinLow |=> !square_wave_enable)
    else $error("square-wave enable kept under reset pin");
  a_reset_access_refused: assert property ((!resetPinN)[*3] ##0 strobe |=> busRefused && !busRvalid)
    else $error("access taken under reset pin");
  a_outage_access_refused: assert property (s_outage ##0 strobe |=> busRefused && !busRvalid)
    else $error("access taken during outage");
  a_outage_no_wave: assert property (s_outage |=> !square_wave_out)
    else $error("square wave during outage");
  a_disabled_no_wave: assert property (!square_wave_enable[*2] |-> !square_wave_out)
    else $error("square wave while disabled");
  a_irq_enabled_flag: assert property ((listed_alarm_flag && periodic_int_enable) || (update_done_flag && update_done_int_enable) |-> !irqPinOeN && any_interrupt_flag)
    else $error("enabled flag without interrupt");
  a_irq_open_drain: assert property (!any_interrupt_flag |-> irqPinOeN && !irqPinOut)
    else $error("interrupt line driven without request");
endmodule // rtcrc_control_chk
bind rtcrc_control rtcrc_control_chk u_rtcrc_control_chk (.clk_sys, .srst, .resetPinN, .power_fail_threshold,
  .busCsN, .busRead, .busWrite, .busRvalid, .busRefused, .irqPinOut, .irqPinOeN, .square_wave_out,
  .periodic_int_enable, .alarm_int_enable, .update_done_int_enable, .square_wave_enable, .listed_alarm_flag,
  .update_done_flag, .any_interrupt_flag);

//--- test/tb_top.sv
// testbench: reset pin, interrupt, square wave, ram clear and outage scenarios
`timescale 1ns/10ps
module tb_top;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic resetPinN = 1'b1;
  logic power_fail_threshold = 1'b0;
  logic ram_clear_n = 1'b1;
  logic oscTick = 1'b0;
  logic alarmEvent = 1'b0;
  logic updateDoneEvent = 1'b0;
  logic busCsN, busRead, busWrite, busRvalid, busRefused, hostAccessOk, irqPinOut, irqPinOeN, irqLine, ok;
  logic square_wave_out, periodic_int_enable, alarm_int_enable, update_done_int_enable, square_wave_enable;
  logic listed_alarm_flag, update_done_flag, any_interrupt_flag;
  logic [6:0] busAddr;
  logic [7:0] busWdata, busRdata, q;
  logic [3:0] rateSelect;
  int fail_count = 0;
  int check_count = 0;
  int cycles = 0;
  always #2.5 clk_sys = ~clk_sys;
  // fast stand-in for the oscillator: one tick every second cycle keeps the taps short
  always @(posedge clk_sys) oscTick <= ~oscTick;
  rtcrc_control u_rtcrc_control (.clk_sys, .srst, .resetPinN, .power_fail_threshold, .ram_clear_n, .oscTick,
    .alarmEvent, .updateDoneEvent, .busCsN, .busRead, .busWrite, .busAddr, .busWdata, .busRdata, .busRvalid,
    .busRefused, .hostAccessOk, .irqPinIn(irqLine), .irqPinOut, .irqPinOeN, .square_wave_out,
    .periodic_int_enable, .alarm_int_enable, .update_done_int_enable, .square_wave_enable, .listed_alarm_flag,
    .update_done_flag, .any_interrupt_flag, .rateSelect);
  rtcrc_host_model u_rtcrc_host_model (.clk_sys, .busCsN, .busRead, .busWrite, .busAddr, .busWdata, .busRdata,
    .busRefused, .irqPinOut, .irqPinOeN, .irqLine);
  // ****************************************************************
  // shared helpers
  // ****************************************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    u_rtcrc_host_model.cycle(1'b1, a, d, q, ok);
  endtask
  task automatic rd(input logic [6:0] a);
    u_rtcrc_host_model.cycle(1'b0, a, 8'h00, q, ok);
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // x on the output is kept by the or, so it cannot pass as quiet
  task automatic quiet(input int n);
    logic s = 1'b0;
    repeat (n) begin
      ticks(1);
      s = s | square_wave_out;
    end
    chk({7'h00, s}, 8'h00);
  endtask
  // cycles until the next rising edge of the square wave
  task automatic edgeGap(output int n);
    n = 0;
    while (square_wave_out === 1'b1 && n < 2000) begin
      ticks(1);
      n++;
    end
    while (square_wave_out !== 1'b1 && n < 2000) begin
      ticks(1);
      n++;
    end
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_irq;
    wr(rtcrc_pkg::ADDR_MODE_CTRL, 8'h78);
    rd(rtcrc_pkg::ADDR_MODE_CTRL);
    chk(q, 8'h78);
    chk({7'h00, busRvalid}, 8'h01);
    @(posedge clk_sys) alarmEvent <= 1'b1;
    @(posedge clk_sys) alarmEvent <= 1'b0;
    #1;
    chk({7'h00, irqLine}, 8'h00);
    rd(rtcrc_pkg::ADDR_INT_STATUS);
    chk(q, 8'hA0);
    chk({7'h00, irqLine}, 8'h01);
    wr(rtcrc_pkg::ADDR_MODE_CTRL, 8'h00);
    @(posedge clk_sys) alarmEvent <= 1'b1;
    @(posedge clk_sys) alarmEvent <= 1'b0;
    ticks(2);
    chk({7'h00, irqLine}, 8'h01);
    rd(rtcrc_pkg::ADDR_INT_STATUS);
    chk(q, 8'h20);
    $display("t_irq done");
  endtask
  task automatic t_reset;
    wr(rtcrc_pkg::ADDR_RATE_CTRL, 8'h03);
    wr(rtcrc_pkg::ADDR_MODE_CTRL, 8'h78);
    wr(rtcrc_pkg::ADDR_RAM_FIRST, 8'h5A);
    // one full tap period so the periodic flag is set before the pin falls
    ticks(8);
    @(posedge clk_sys) updateDoneEvent <= 1'b1;
    @(posedge clk_sys) updateDoneEvent <= 1'b0;
    ticks(1);
    chk({4'h0, listed_alarm_flag, update_done_flag, any_interrupt_flag, irqLine}, 8'h0E);
    // held only a few cycles here; a board keeps the pin low past the power-up timer
    @(posedge clk_sys) resetPinN <= 1'b0;
    ticks(4);
    chk({periodic_int_enable, alarm_int_enable, update_done_int_enable, square_wave_enable}, 8'h00);
    chk({listed_alarm_flag, update_done_flag, any_interrupt_flag, irqLine}, 8'h01);
    chk({7'h00, hostAccessOk}, 8'h00);
    rd(rtcrc_pkg::ADDR_RAM_FIRST);
    chk({7'h00, ok}, 8'h00);
    chk({6'h00, busRvalid, busRefused}, 8'h01);
    @(posedge clk_sys) resetPinN <= 1'b1;
    ticks(4);
    chk({7'h00, hostAccessOk}, 8'h01);
    rd(rtcrc_pkg::ADDR_RAM_FIRST);
    chk(q, 8'h5A);
    $display("t_reset done");
  endtask
  task automatic t_sqw;
    int b;
    int n;
    wr(rtcrc_pkg::ADDR_MODE_CTRL, 8'h08);
    // one period per tap: bit b of the divider flips every 2^b ticks, a tick every 2 cycles
    for (int r = 1; r < 9; r++) begin
      wr(rtcrc_pkg::ADDR_RATE_CTRL, 8'(r));
      b = (r == 1) ? 6 : (r == 2) ? 7 : r - 2;
      edgeGap(n);
      edgeGap(n);
      chk({7'h00, n == (1 << (b + 2))}, 8'h01);
    end
    wr(rtcrc_pkg::ADDR_RATE_CTRL, 8'h00);
    quiet(300);
    wr(rtcrc_pkg::ADDR_RATE_CTRL, 8'h03);
    wr(rtcrc_pkg::ADDR_MODE_CTRL, 8'h00);
    quiet(40);
    $display("t_sqw done");
  endtask
  task automatic t_power;
    wr(rtcrc_pkg::ADDR_RAM_FIRST, 8'h33);
    wr(rtcrc_pkg::ADDR_MODE_CTRL, 8'h08);
    @(posedge clk_sys) ram_clear_n <= 1'b0;
    @(posedge clk_sys) ram_clear_n <= 1'b1;
    ticks(4);
    rd(rtcrc_pkg::ADDR_RAM_FIRST);
    chk(q, 8'h33);
    @(posedge clk_sys) power_fail_threshold <= 1'b1;
    ticks(4);
    quiet(40);
    chk({7'h00, hostAccessOk}, 8'h00);
    wr(rtcrc_pkg::ADDR_RAM_LAST, 8'h00);
    chk({7'h00, ok}, 8'h00);
    rd(rtcrc_pkg::ADDR_RATE_CTRL);
    chk({7'h00, ok}, 8'h00);
    @(posedge clk_sys) ram_clear_n <= 1'b0;
    ticks(4);
    @(posedge clk_sys) ram_clear_n <= 1'b1;
    @(posedge clk_sys) power_fail_threshold <= 1'b0;
    ticks(4);
    rd(rtcrc_pkg::ADDR_RAM_LAST);
    chk(q, rtcrc_pkg::RAM_CLEAR_VALUE);
    rd(rtcrc_pkg::ADDR_RATE_CTRL);
    chk(q, 8'h03);
    chk({4'h0, rateSelect}, 8'h03);
    $display("t_power done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // hang guard well above the longest expected run
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      final_report();
    end
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    srst <= 1'b0;
    ticks(2);
    t_irq();
    t_reset();
    t_sqw();
    t_power();
    final_report();
  end
endmodule // tb_top
